// ### src/dcld_cfg.svh
`ifndef DCLD_CFG_SVH
`define DCLD_CFG_SVH

// Register offsets (byte-wide registers, printed offsets)
`define DCLD_OFS_AVG_LO      8'h06
`define DCLD_OFS_RAMP_SETTLE 8'h07
`define DCLD_OFS_THR_CH12    8'h08
`define DCLD_OFS_THR_CH34    8'h09
`define DCLD_OFS_FLT_CH12    8'h0A
`define DCLD_OFS_FLT_CH34    8'h0B
`define DCLD_OFS_LO_RPT      8'h0C

// Reset values
`define DCLD_RST_AVG_LO      8'h00
`define DCLD_RST_RAMP_SETTLE 8'h00
`define DCLD_RST_THR         8'h11
`define DCLD_RST_REPORT      8'h00

// Field positions
`define DCLD_RAIL_AVG_BIT    6
`define DCLD_LOAD_AVG_HI     5
`define DCLD_LOAD_AVG_LO     4
`define DCLD_LOAD_RAMP_HI    7
`define DCLD_LOAD_SETTLE_HI  5
`define DCLD_RAIL_RAMP_HI    3
`define DCLD_RAIL_SETTLE_HI  1
`define DCLD_STATE_DIAG      2'b11
`define DCLD_THR_MAX_CODE    4'h9

// Timing: clock period and tick period in ns
`define DCLD_CLK_NS          40
`define DCLD_TICK_NS         100000

// Durations in 0.1 ms ticks
`define DCLD_T_0P2MS         10'h002
`define DCLD_T_0P7MS         10'h007
`define DCLD_T_10P7MS        10'h06B
`define DCLD_T_21P3MS        10'h0D5
`define DCLD_T_42P7MS        10'h1AB
`define DCLD_T_2P5MS         10'h019
`define DCLD_T_5MS           10'h032
`define DCLD_T_10MS          10'h064
`define DCLD_T_15MS          10'h096
`define DCLD_T_20MS          10'h0C8
`define DCLD_T_30MS          10'h12C

`endif

// ### src/dcld_pkg.sv
`default_nettype none
package dcld_pkg;
  typedef enum logic [1:0] {
    DCLD_IDLE,
    DCLD_RAMP,
    DCLD_SETTLE,
    DCLD_AVG
  } dcld_state_t;
endpackage
`default_nettype wire

// ### src/dcld_regs.sv
// Operation
// - Bit 6 of averaging register picks rail-short averaging 0.2 or 0.7 ms.
// - Bits 5-4 pick load-test averaging 10.7/21.3/42.7 ms; 00 reuses bit 6.
// - Bits 3..0 enable line-out checking for channels 1..4.
// - Timing bits 7-6 pick load-test ramp 15/30/10/20 ms.
// - Timing bits 5-4 pick load-test settling 10/5/20/15 ms.
// - Timing bits 3-2 pick rail-short ramp 5/2.5/10/15 ms.
// - Timing bits 1-0 pick rail-short settling 10/5/20/30 ms.
// - Four-bit shorted-load codes; ch1 upper, ch2 lower nibble.
// - Ch3/ch4 thresholds in next register; both reset to 0x11.
// - Report register: ch1 flags bits 7-4, ch2 flags bits 3-0.
// - Second report register: ch3 flags bits 7-4, ch4 bits 3-0.
// - Line-out report bits 3..0 for ch1..4; upper bits read zero.
// - Report registers reset to zero and ignore writes.
// - Ramp and settling register resets to zero.
// - State code 11 written for a channel starts its diagnostic.
// - Leaving hi-Z or a fault starts diagnostic unless skip is set.
`timescale 1ns/1ps
`default_nettype none
`include "dcld_cfg.svh"

module dcld_regs
  import dcld_pkg::*;
#(
  parameter int TICK_CYCLES = `DCLD_TICK_NS / `DCLD_CLK_NS
) (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       state_ctrl_wr,
  input  wire logic [7:0] channel_state_req,
  input  wire logic       auto_diag_skip,
  input  wire logic [3:0] hiz_exit,
  input  wire logic [3:0] chan_fault,
  input  wire logic [3:0] meas_ground_short,
  input  wire logic [3:0] meas_supply_short,
  input  wire logic [3:0] meas_open_load,
  input  wire logic [3:0] meas_shorted_load,
  input  wire logic [3:0] meas_lineout,
  output logic            diag_busy,
  output logic      [1:0] diag_chan,
  output logic            diag_group,
  output logic            diag_ramp,
  output logic            diag_settle,
  output logic            diag_average,
  output logic      [4:0] thresh_half_ohm,
  output logic            thresh_valid,
  output logic            diag_done
);

  logic             rst_m_ff;
  logic             rst_s_ff;
  logic [7:0]       avg_lo_ff;
  logic [7:0]       ramp_settle_ff;
  logic [7:0]       thr12_ff;
  logic [7:0]       thr34_ff;
  logic [3:0]       flags_ff [4];
  logic [3:0]       lineout_ff;
  logic [4:0][3:0]  meas_m_ff;
  logic [4:0][3:0]  meas_s_ff;
  logic [3:0]       pend_ff;
  logic [3:0]       start_req;
  dcld_state_t      state_ff;
  logic [1:0]       chan_ff;
  logic             group_ff;
  logic [9:0]       tmr_ff;
  logic [15:0]      pre_ff;
  logic             tick;
  logic             phase_end;
  logic             seq_start;
  logic [1:0]       pick;
  logic [4:0]       thr_ff;
  logic             thr_ok_ff;
  logic             done_ff;
  logic [7:0]       rdata_ff;
  logic [3:0]       sel_code;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_m_ff <= 1'b0;
      rst_s_ff <= 1'b0;
    end else begin
      rst_m_ff <= 1'b1;
      rst_s_ff <= rst_m_ff;
    end
  end

  // Analog comparator results are asynchronous to the clock
  always_ff @(posedge clock or negedge rst_s_ff) begin
    if (!rst_s_ff) begin
      meas_m_ff <= '0;
      meas_s_ff <= '0;
    end else begin
      meas_m_ff <= {meas_lineout, meas_shorted_load, meas_open_load,
                    meas_supply_short, meas_ground_short};
      meas_s_ff <= meas_m_ff;
    end
  end

  function automatic logic [9:0] avg_ticks(input logic       grp,
                                           input logic [7:0] cfg);
    logic [9:0] rail;
    rail = cfg[`DCLD_RAIL_AVG_BIT] ? `DCLD_T_0P7MS : `DCLD_T_0P2MS;
    if (!grp) begin
      avg_ticks = rail;
    end else begin
      unique case (cfg[`DCLD_LOAD_AVG_HI:`DCLD_LOAD_AVG_LO])
        2'b00: avg_ticks = rail;
        2'b01: avg_ticks = `DCLD_T_10P7MS;
        2'b10: avg_ticks = `DCLD_T_21P3MS;
        2'b11: avg_ticks = `DCLD_T_42P7MS;
      endcase
    end
  endfunction

  function automatic logic [9:0] ramp_ticks(input logic       grp,
                                            input logic [7:0] cfg);
    if (grp) begin
      unique case (cfg[`DCLD_LOAD_RAMP_HI -: 2])
        2'b00: ramp_ticks = `DCLD_T_15MS;
        2'b01: ramp_ticks = `DCLD_T_30MS;
        2'b10: ramp_ticks = `DCLD_T_10MS;
        2'b11: ramp_ticks = `DCLD_T_20MS;
      endcase
    end else begin
      unique case (cfg[`DCLD_RAIL_RAMP_HI -: 2])
        2'b00: ramp_ticks = `DCLD_T_5MS;
        2'b01: ramp_ticks = `DCLD_T_2P5MS;
        2'b10: ramp_ticks = `DCLD_T_10MS;
        2'b11: ramp_ticks = `DCLD_T_15MS;
      endcase
    end
  endfunction

  function automatic logic [9:0] settle_ticks(input logic       grp,
                                              input logic [7:0] cfg);
    if (grp) begin
      unique case (cfg[`DCLD_LOAD_SETTLE_HI -: 2])
        2'b00: settle_ticks = `DCLD_T_10MS;
        2'b01: settle_ticks = `DCLD_T_5MS;
        2'b10: settle_ticks = `DCLD_T_20MS;
        2'b11: settle_ticks = `DCLD_T_15MS;
      endcase
    end else begin
      unique case (cfg[`DCLD_RAIL_SETTLE_HI -: 2])
        2'b00: settle_ticks = `DCLD_T_10MS;
        2'b01: settle_ticks = `DCLD_T_5MS;
        2'b10: settle_ticks = `DCLD_T_20MS;
        2'b11: settle_ticks = `DCLD_T_30MS;
      endcase
    end
  endfunction

  // Configuration registers
  always_ff @(posedge clock or negedge rst_s_ff) begin
    if (!rst_s_ff) begin
      avg_lo_ff      <= `DCLD_RST_AVG_LO;
      ramp_settle_ff <= `DCLD_RST_RAMP_SETTLE;
      thr12_ff       <= `DCLD_RST_THR;
      thr34_ff       <= `DCLD_RST_THR;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `DCLD_OFS_AVG_LO:      avg_lo_ff      <= reg_wdata;
        `DCLD_OFS_RAMP_SETTLE: ramp_settle_ff <= reg_wdata;
        `DCLD_OFS_THR_CH12:    thr12_ff       <= reg_wdata;
        `DCLD_OFS_THR_CH34:    thr34_ff       <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Requests from the state control field and autonomous triggers
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      start_req[i] = (state_ctrl_wr
                      && channel_state_req[7-2*i -: 2] == `DCLD_STATE_DIAG)
                  || (!auto_diag_skip
                      && (hiz_exit[i] || chan_fault[i]));
    end
  end

  always_comb begin
    pick = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (pend_ff[i]) begin
        pick = i[1:0];
      end
    end
  end

  assign seq_start = (state_ff == DCLD_IDLE) && (pend_ff != 4'h0);
  assign tick      = (pre_ff == 16'(TICK_CYCLES - 1));
  assign phase_end = (state_ff != DCLD_IDLE) && tick && (tmr_ff == 10'h001);

  // A request arriving as its channel is taken stays pending
  always_ff @(posedge clock or negedge rst_s_ff) begin
    if (!rst_s_ff) begin
      pend_ff <= 4'h0;
    end else begin
      pend_ff <= (pend_ff & ~(seq_start ? (4'h1 << pick) : 4'h0)) | start_req;
    end
  end

  // Prescaler restarts at every phase so each phase is whole ticks
  always_ff @(posedge clock or negedge rst_s_ff) begin
    if (!rst_s_ff) begin
      pre_ff <= 16'h0000;
    end else if (seq_start || phase_end || tick) begin
      pre_ff <= 16'h0000;
    end else begin
      pre_ff <= pre_ff + 16'h0001;
    end
  end

  always_ff @(posedge clock or negedge rst_s_ff) begin
    if (!rst_s_ff) begin
      state_ff <= DCLD_IDLE;
      chan_ff  <= 2'h0;
      group_ff <= 1'b0;
      tmr_ff   <= 10'h000;
    end else begin
      unique case (state_ff)
        DCLD_IDLE: begin
          if (seq_start) begin
            state_ff <= DCLD_RAMP;
            chan_ff  <= pick;
            group_ff <= 1'b0;
            tmr_ff   <= ramp_ticks(1'b0, ramp_settle_ff);
          end
        end
        DCLD_RAMP: begin
          if (phase_end) begin
            state_ff <= DCLD_SETTLE;
            tmr_ff   <= settle_ticks(group_ff, ramp_settle_ff);
          end else if (tick) begin
            tmr_ff <= tmr_ff - 10'h001;
          end
        end
        DCLD_SETTLE: begin
          if (phase_end) begin
            state_ff <= DCLD_AVG;
            tmr_ff   <= avg_ticks(group_ff, avg_lo_ff);
          end else if (tick) begin
            tmr_ff <= tmr_ff - 10'h001;
          end
        end
        DCLD_AVG: begin
          if (phase_end && !group_ff) begin
            state_ff <= DCLD_RAMP;
            group_ff <= 1'b1;
            tmr_ff   <= ramp_ticks(1'b1, ramp_settle_ff);
          end else if (phase_end) begin
            state_ff <= DCLD_IDLE;
            group_ff <= 1'b0;
          end else if (tick) begin
            tmr_ff <= tmr_ff - 10'h001;
          end
        end
      endcase
    end
  end

  // Flags of the channel under test clear at start, land after averaging
  always_ff @(posedge clock or negedge rst_s_ff) begin
    if (!rst_s_ff) begin
      for (int i = 0; i < 4; i++) begin
        flags_ff[i] <= 4'h0;
      end
      lineout_ff <= 4'h0;
    end else if (seq_start) begin
      flags_ff[pick]       <= 4'h0;
      lineout_ff[3 - pick] <= 1'b0;
    end else if (phase_end && state_ff == DCLD_AVG) begin
      if (!group_ff) begin
        flags_ff[chan_ff][3:2] <= {meas_s_ff[0][chan_ff],
                                   meas_s_ff[1][chan_ff]};
      end else begin
        flags_ff[chan_ff][1:0] <= {meas_s_ff[2][chan_ff],
                                   meas_s_ff[3][chan_ff]};
        lineout_ff[3 - chan_ff] <= avg_lo_ff[3 - chan_ff]
                                 & meas_s_ff[4][chan_ff];
      end
    end
  end

  always_comb begin
    unique case (pick)
      2'h0: sel_code = thr12_ff[7:4];
      2'h1: sel_code = thr12_ff[3:0];
      2'h2: sel_code = thr34_ff[7:4];
      2'h3: sel_code = thr34_ff[3:0];
    endcase
  end

  // Threshold latched at start so mid-test writes cannot move it
  always_ff @(posedge clock or negedge rst_s_ff) begin
    if (!rst_s_ff) begin
      thr_ff    <= 5'h00;
      thr_ok_ff <= 1'b0;
      done_ff   <= 1'b0;
    end else begin
      done_ff <= phase_end && state_ff == DCLD_AVG && group_ff;
      if (seq_start) begin
        thr_ff    <= {1'b0, sel_code} + 5'h01;
        thr_ok_ff <= (sel_code <= `DCLD_THR_MAX_CODE);
      end
    end
  end

  // Read data registered; writes to report offsets fall through
  always_ff @(posedge clock or negedge rst_s_ff) begin
    if (!rst_s_ff) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `DCLD_OFS_AVG_LO:      rdata_ff <= avg_lo_ff;
        `DCLD_OFS_RAMP_SETTLE: rdata_ff <= ramp_settle_ff;
        `DCLD_OFS_THR_CH12:    rdata_ff <= thr12_ff;
        `DCLD_OFS_THR_CH34:    rdata_ff <= thr34_ff;
        `DCLD_OFS_FLT_CH12:    rdata_ff <= {flags_ff[0], flags_ff[1]};
        `DCLD_OFS_FLT_CH34:    rdata_ff <= {flags_ff[2], flags_ff[3]};
        `DCLD_OFS_LO_RPT:      rdata_ff <= {4'h0, lineout_ff};
        default:               rdata_ff <= 8'h00;
      endcase
    end
  end

  assign reg_rdata       = rdata_ff;
  assign diag_busy       = (state_ff != DCLD_IDLE);
  assign diag_chan       = chan_ff;
  assign diag_group      = group_ff;
  assign diag_ramp       = (state_ff == DCLD_RAMP);
  assign diag_settle     = (state_ff == DCLD_SETTLE);
  assign diag_average    = (state_ff == DCLD_AVG);
  assign thresh_half_ohm = thr_ff;
  assign thresh_valid    = thr_ok_ff;
  assign diag_done       = done_ff;

endmodule

`default_nettype wire

// ### test/dcld_load_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcld_load_model (
  input  wire logic        diag_average,
  input  wire logic        diag_group,
  input  wire logic [19:0] load_kind,
  output logic      [19:0] meas
);
  logic [19:0] live;
  // Comparators read inverted outside their own averaging window, so a
  // capture in the wrong phase or group shows up in the report
  assign live = {20{diag_average}}
              & (diag_group ? 20'h0_0FFF : 20'hF_F000);
  assign meas = load_kind ^ ~live;
endmodule
`default_nettype wire

// ### test/dcld_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dcld_regs_bench;
  localparam int TC = 4;
  localparam int RR[4] = '{50, 25, 100, 150};
  localparam int RS[4] = '{100, 50, 200, 300};
  localparam int LR[4] = '{150, 300, 100, 200};
  localparam int LS[4] = '{100, 50, 200, 150};
  localparam int LA[4] = '{0, 107, 213, 427};
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  channel_state_req = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        state_ctrl_wr = 1'b0;
  logic        auto_diag_skip = 1'b0;
  logic [3:0]  hiz_exit = 4'h0;
  logic [3:0]  chan_fault = 4'h0;
  logic [19:0] load_kind = 20'h5_396F;
  logic [19:0] meas;
  logic [7:0]  reg_rdata;
  logic [1:0]  diag_chan;
  logic [4:0]  thresh_half_ohm;
  logic        diag_busy, diag_group, diag_ramp, diag_settle;
  logic        diag_average, thresh_valid, diag_done;
  logic [3:0]  nib[4];
  int          miscompares = 0;
  int          checked = 0;
  always #20 clock = ~clock;
  dcld_regs #(.TICK_CYCLES(TC)) dcld_regs_i (.clock, .nrst, .reg_addr,
    .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .state_ctrl_wr,
    .channel_state_req, .auto_diag_skip, .hiz_exit, .chan_fault,
    .meas_ground_short(meas[19:16]), .meas_supply_short(meas[15:12]),
    .meas_open_load(meas[11:8]), .meas_shorted_load(meas[7:4]),
    .meas_lineout(meas[3:0]), .diag_busy, .diag_chan, .diag_group,
    .diag_ramp, .diag_settle, .diag_average, .thresh_half_ohm,
    .thresh_valid, .diag_done);
  dcld_load_model dcld_load_model_i (.diag_average, .diag_group, .load_kind,
    .meas);
  function automatic logic sig(int p);
    logic [4:0] s;
    s = {diag_done, diag_busy, diag_average, diag_settle, diag_ramp};
    return s[p];
  endfunction
  task automatic end_of_test();
    if (miscompares == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    check("reg_rdata", 16'(exp), 16'(reg_rdata));
  endtask
  task automatic wait_for(int p, logic lvl);
    int n;
    n = 0;
    while (sig(p) !== lvl) begin
      @(negedge clock);
      n++;
      if (n > 20000) begin
        miscompares++;
        end_of_test();
      end
    end
  endtask
  task automatic phase(int p, int ticks);
    int n;
    wait_for(p, 1'b1);
    n = 0;
    while (sig(p) === 1'b1 && n < 20000) begin
      @(negedge clock);
      n++;
    end
    check("phase length", 16'(ticks * TC), 16'(n));
  endtask
  task automatic run(int k);
    logic [3:0] code;
    int ra;
    code = (k == 0) ? 4'h9 : (k == 1) ? 4'hA : (k == 2) ? 4'h0 : 4'hF;
    ra = k[0] ? 7 : 2;
    wait_for(3, 1'b1);
    check("diag_chan", 16'(k), 16'(diag_chan));
    check("thresh_half_ohm", 16'(code + 5'h01), 16'(thresh_half_ohm));
    check("thresh_valid", 16'(code <= 4'h9), 16'(thresh_valid));
    phase(0, RR[k]);
    phase(1, RS[k]);
    phase(2, ra);
    phase(0, LR[k]);
    phase(1, LS[k]);
    phase(2, (k == 0) ? ra : LA[k]);
    wait_for(4, 1'b1);
    wait_for(3, 1'b0);
  endtask
  initial begin
    repeat (12) @(posedge clock);
    @(negedge clock);
    nrst = 1'b1;
    repeat (4) @(negedge clock);
    for (int a = 6; a < 14; a++) begin
      rd(8'(a), (a == 8 || a == 9) ? 8'h11 : 8'h00);
    end
    for (int a = 10; a < 14; a++) begin
      wr(8'(a), 8'hFF);
      rd(8'(a), 8'h00);
    end
    wr(8'h08, 8'h9A);
    wr(8'h09, 8'h0F);
    rd(8'h08, 8'h9A);
    rd(8'h09, 8'h0F);
    // Skip must hold off both autonomous triggers
    auto_diag_skip = 1'b1;
    hiz_exit = 4'hF;
    chan_fault = 4'hF;
    @(negedge clock);
    hiz_exit = 4'h0;
    chan_fault = 4'h0;
    repeat (5) @(negedge clock);
    check("diag_busy", 16'h0000, 16'(diag_busy));
    auto_diag_skip = 1'b0;
    for (int k = 0; k < 4; k++) begin
      wr(8'h06, {1'b1, k[0], k[1:0], 4'hA});
      wr(8'h07, {4{k[1:0]}});
      rd(8'h06, {1'b1, k[0], k[1:0], 4'hA});
      rd(8'h07, {4{k[1:0]}});
      @(negedge clock);
      state_ctrl_wr = (k == 0 || k == 3);
      channel_state_req = (k == 0) ? 8'hC0 : 8'h03;
      hiz_exit = (k == 1) ? 4'h2 : 4'h0;
      chan_fault = (k == 2) ? 4'h4 : 4'h0;
      @(negedge clock);
      state_ctrl_wr = 1'b0;
      hiz_exit = 4'h0;
      chan_fault = 4'h0;
      run(k);
    end
    for (int i = 0; i < 4; i++) begin
      nib[i] = {load_kind[16+i], load_kind[12+i],
                load_kind[8+i], load_kind[4+i]};
    end
    rd(8'h0A, {nib[0], nib[1]});
    rd(8'h0B, {nib[2], nib[3]});
    rd(8'h0C, 8'h0A);
    // Restart ch1: only its flags clear; a reset mid-test clears all
    @(negedge clock);
    state_ctrl_wr = 1'b1;
    channel_state_req = 8'hC0;
    @(negedge clock);
    state_ctrl_wr = 1'b0;
    wait_for(3, 1'b1);
    rd(8'h0A, {4'h0, nib[1]});
    nrst = 1'b0;
    @(negedge clock);
    nrst = 1'b1;
    repeat (4) @(negedge clock);
    check("diag_busy", 16'h0000, 16'(diag_busy));
    for (int a = 7; a < 13; a++) begin
      rd(8'(a), (a == 8 || a == 9) ? 8'h11 : 8'h00);
    end
    end_of_test();
  end
endmodule
`default_nettype wire

// ### test/dcld_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module dcld_regs_checker (
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       state_ctrl_wr,
  input wire logic [7:0] channel_state_req,
  input wire logic       diag_busy,
  input wire logic [1:0] diag_chan,
  input wire logic       diag_group,
  input wire logic       diag_ramp,
  input wire logic       diag_settle,
  input wire logic       diag_average,
  input wire logic [4:0] thresh_half_ohm,
  input wire logic       thresh_valid,
  input wire logic       diag_done
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_start;
    state_ctrl_wr && channel_state_req[7:6] == 2'b11 && !diag_busy;
  endsequence
  sequence s_rail_end;
    $fell(diag_average) && diag_busy;
  endsequence
  sequence s_load_end;
    $fell(diag_average) && !diag_busy;
  endsequence
  property p_start; s_start |-> ##2 diag_busy; endproperty
  property p_phase;
    $countones({diag_ramp, diag_settle, diag_average}) == (diag_busy ? 1 : 0);
  endproperty
  property p_settle; $fell(diag_ramp) |-> diag_settle; endproperty
  property p_avg; $fell(diag_settle) |-> diag_average; endproperty
  property p_group; s_rail_end |-> diag_ramp && diag_group; endproperty
  property p_done; s_load_end |-> diag_done ##1 !diag_done; endproperty
  property p_entry; $rose(diag_busy) |-> diag_ramp && !diag_group;
  endproperty
  property p_done_end; diag_done |-> $fell(diag_average) && !diag_busy;
  endproperty
  property p_thr; diag_busy |-> thresh_valid == (thresh_half_ohm <= 5'h0A);
  endproperty
  property p_chan; diag_busy && $past(diag_busy) |-> $stable(diag_chan);
  endproperty
  property p_lo_rsvd; reg_rd && reg_addr == 8'h0C |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  a_phase: assert property (p_phase) else $error("bad phase");
  a_settle: assert property (p_settle) else $error("no settle");
  a_avg: assert property (p_avg) else $error("no average");
  a_group: assert property (p_group) else $error("no load group");
  a_done: assert property (p_done) else $error("bad done");
  a_thr: assert property (p_thr) else $error("bad threshold valid");
  a_chan: assert property (p_chan) else $error("channel moved");
  a_lo_rsvd: assert property (p_lo_rsvd) else $error("reserved set");
  a_entry: assert property (p_entry) else $error("no rail ramp");
  a_done_end: assert property (p_done_end) else $error("stray done");
endmodule
bind dcld_regs dcld_regs_checker dcld_regs_checker_i (.clock, .nrst, .reg_addr,
  .reg_rd, .reg_rdata, .state_ctrl_wr, .channel_state_req, .diag_busy,
  .diag_chan, .diag_group, .diag_ramp, .diag_settle, .diag_average,
  .thresh_half_ohm, .thresh_valid, .diag_done);
`default_nettype wire
